// file: core/bcr_reset_ctrl.sv
// bcr_reset_ctrl.sv: reset sequencing and boot configuration capture
// assumes straps and fundamental_reset_n are asynchronous pins; others are core_clk logic
//
// Behaviour
// - refclk select strap low means 100 MHz, high means 125 MHz.
// - each PLL yields a 2.5 GHz lane clock and 250 MHz core clock.
// - common clock straps report shared reference per upstream and downstream side.
// - boot vector captured only at fundamental reset release, ignored otherwise.
// - serial memory initialization may change any software visible register bit.
// - memory or slave bus may override overridable boot bits during fundamental reset.
// - slow strap makes master bus 100 KHz not 400 KHz, never overridden.
// - status reports boot values sampled at most recent cold reset.
// - fundamental reset input resets all logic and starts link fundamental reset.
// - halt strap keeps device in reset after sequence, management buses active.
// - clearing the control halt bit releases the halted reset state.
// - mode 0x0 normal, 0x1 normal with memory init, others reserved.
// - four reset kinds: fundamental, hot, upstream and downstream secondary bus.
// - fundamental reset clears all logic including sticky fields.
// - hot reset clears logic but keeps sticky fields.
// - upstream secondary bus reset hot-resets all but upstream bridge.
// - downstream secondary bus reset propagates hot reset onto its link.
// - first reset after power-up is cold, later fundamental resets are warm.
// - writing the fundamental reset request bit starts a warm fundamental reset.
// - reset without input assertion reuses previously sampled boot values.
// - halt strap sets status halt bit during reset sequence.
`timescale 1ns/1ps
`default_nettype none
`include "bcr_consts.svh"
module bcr_reset_ctrl
  import bcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic fundamental_reset_n,
  input wire logic refclk_freq_select,
  input wire logic common_clock_upstream,
  input wire logic common_clock_downstream,
  input wire logic master_mgmt_bus_slow_select,
  input wire logic halt_after_reset,
  input wire logic [`BCR_MODE_W-1:0] switch_operating_mode_sel,
  input wire logic fundamental_reset_request,
  input wire logic halt_clear,
  input wire logic hot_reset_req,
  input wire logic us_sec_bus_reset_req,
  input wire logic ds_sec_bus_reset_req,
  input wire logic ovr_valid,
  input wire bcr_boot_s ovr_boot,
  input wire logic eeprom_init_done,
  output logic core_reset_n,
  output logic sticky_reset_n,
  output logic link_fund_reset,
  output logic vbus_hot_reset,
  output logic us_bridge_hot_reset,
  output logic ds_link_hot_reset,
  output logic eeprom_init_start,
  output logic mgmt_bus_enable,
  output logic mbus_slow_mode,
  output logic refclk_is_125,
  output logic ssc_must_disable,
  output logic mode_reserved,
  output logic cold_reset_seen,
  output bcr_boot_s switch_status_register,
  output bcr_boot_s boot_active
);
  // pin synchronisers
  logic [1:0] prst_sync_r;
  logic [8:0] strap_s1_r;
  logic [8:0] strap_s2_r;
  logic pin_seen_r;
  logic [7:0] settle_r;
  logic [7:0] settle_nxt;
  logic powered_r;
  logic warm_req_r;
  logic halt_r;
  logic eeprom_busy_r;
  bcr_state_e state_r;
  bcr_state_e state_nxt;
  bcr_boot_s sampled_r;
  bcr_boot_s cold_r;
  bcr_boot_s strap_w;
  bcr_boot_s merged_w;
  wire pin_rst_w = ~prst_sync_r[1];
  wire fund_w = pin_rst_w | warm_req_r;
  wire in_reset_w = (state_r != BCR_ST_RUN);
  wire eeprom_mode_w = (sampled_r.mode == `BCR_MODE_NORMAL_EEPROM);
  wire settled_w = (settle_r == 8'h00);
  wire eeprom_busy_nxt_w = (pin_seen_r ? strap_w.mode : sampled_r.mode) == `BCR_MODE_NORMAL_EEPROM;

  always_ff @(posedge core_clk) begin
    prst_sync_r <= {prst_sync_r[0], fundamental_reset_n};
  end

  always_ff @(posedge core_clk) begin
    strap_s1_r <= {switch_operating_mode_sel, halt_after_reset, master_mgmt_bus_slow_select,
                   common_clock_upstream, common_clock_downstream, refclk_freq_select};
    strap_s2_r <= strap_s1_r;
  end

  // straps read only through the second stage
  assign strap_w.mode = strap_s2_r[8:5];
  assign strap_w.halt = strap_s2_r[4];
  assign strap_w.mbus_slow = strap_s2_r[3];
  assign strap_w.cclk_us = strap_s2_r[2];
  assign strap_w.cclk_ds = strap_s2_r[1];
  assign strap_w.refclk_hi = strap_s2_r[0];

  // override merge: slow mode keeps the sampled value
  always_comb begin
    merged_w = sampled_r;
    if (ovr_valid && in_reset_w) begin
      merged_w = ovr_boot;
      merged_w.mbus_slow = sampled_r.mbus_slow;
    end
  end

  always_comb begin
    state_nxt = state_r;
    settle_nxt = (settle_r == 8'h00) ? 8'h00 : settle_r - 8'h01;
    unique case (state_r)
      BCR_ST_RESET: if (!fund_w) begin
        state_nxt = BCR_ST_SAMPLE;
      end
      BCR_ST_SAMPLE: begin
        state_nxt = BCR_ST_INIT;
        settle_nxt = `BCR_SETTLE_CYC;
      end
      BCR_ST_INIT: if (settled_w && !eeprom_busy_r) begin
        state_nxt = halt_r ? BCR_ST_HALT : BCR_ST_RUN;
      end
      BCR_ST_HALT: if (halt_clear) begin
        state_nxt = BCR_ST_RUN;
      end
      BCR_ST_RUN: ;
    endcase
    if (fund_w) begin
      state_nxt = BCR_ST_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= BCR_ST_RESET;
      settle_r <= 8'h00;
      powered_r <= 1'b0;
      warm_req_r <= 1'b0;
      halt_r <= 1'b0;
      eeprom_busy_r <= 1'b0;
      sampled_r <= '0;
      cold_r <= '0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      // request held until the reset state is reached
      if (fundamental_reset_request) begin
        warm_req_r <= 1'b1;
      end else if (state_r == BCR_ST_RESET) begin
        warm_req_r <= 1'b0;
      end
      if (state_r == BCR_ST_SAMPLE) begin
        if (pin_seen_r) begin
          sampled_r <= strap_w;
          if (!powered_r) begin
            cold_r <= strap_w;
          end
        end
        powered_r <= 1'b1;
        eeprom_busy_r <= eeprom_busy_nxt_w;
      end else if (in_reset_w) begin
        sampled_r <= merged_w;
      end
      if (state_r == BCR_ST_INIT && eeprom_init_done) begin
        eeprom_busy_r <= 1'b0;
      end
      if (state_r == BCR_ST_INIT) begin
        halt_r <= sampled_r.halt;
      end else if (state_r == BCR_ST_HALT && halt_clear) begin
        halt_r <= 1'b0;
      end else if (state_r == BCR_ST_RESET) begin
        halt_r <= 1'b0;
      end
    end
  end

  // pin assertion seen since last sample
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_seen_r <= 1'b1;
    end else if (pin_rst_w) begin
      pin_seen_r <= 1'b1;
    end else if (state_r == BCR_ST_SAMPLE) begin
      pin_seen_r <= 1'b0;
    end
  end

  // next values of the registered outputs
  wire core_reset_n_nxt = (state_r == BCR_ST_RUN) && !fund_w && !hot_reset_req;
  wire sticky_reset_n_nxt = !fund_w && (state_r != BCR_ST_RESET);
  wire link_fund_reset_nxt = (state_r == BCR_ST_RESET);
  wire vbus_hot_reset_nxt = hot_reset_req | us_sec_bus_reset_req;
  wire us_bridge_hot_reset_nxt = hot_reset_req;
  wire ds_link_hot_reset_nxt = hot_reset_req | ds_sec_bus_reset_req;
  wire eeprom_init_start_nxt = (state_r == BCR_ST_SAMPLE) && eeprom_busy_nxt_w;
  wire mgmt_bus_enable_nxt = (state_r == BCR_ST_HALT) || (state_r == BCR_ST_RUN) || (state_r == BCR_ST_INIT);
  wire ssc_must_disable_nxt = !(sampled_r.cclk_us && sampled_r.cclk_ds);
  wire mode_reserved_nxt = (sampled_r.mode != `BCR_MODE_NORMAL) && !eeprom_mode_w;

  // status shows cold-sampled straps with a live halt bit
  bcr_boot_s status_nxt_w;
  assign status_nxt_w.mode = cold_r.mode;
  assign status_nxt_w.halt = halt_r;
  assign status_nxt_w.mbus_slow = cold_r.mbus_slow;
  assign status_nxt_w.cclk_us = cold_r.cclk_us;
  assign status_nxt_w.cclk_ds = cold_r.cclk_ds;
  assign status_nxt_w.refclk_hi = cold_r.refclk_hi;

  // reset outputs
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= core_reset_n_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sticky_reset_n <= 1'b0;
    end else begin
      sticky_reset_n <= sticky_reset_n_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      link_fund_reset <= 1'b1;
    end else begin
      link_fund_reset <= link_fund_reset_nxt;
    end
  end

  // hot and secondary bus resets
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      vbus_hot_reset <= 1'b0;
    end else begin
      vbus_hot_reset <= vbus_hot_reset_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      us_bridge_hot_reset <= 1'b0;
    end else begin
      us_bridge_hot_reset <= us_bridge_hot_reset_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ds_link_hot_reset <= 1'b0;
    end else begin
      ds_link_hot_reset <= ds_link_hot_reset_nxt;
    end
  end

  // init and management bus
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      eeprom_init_start <= 1'b0;
    end else begin
      eeprom_init_start <= eeprom_init_start_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mgmt_bus_enable <= 1'b0;
    end else begin
      mgmt_bus_enable <= mgmt_bus_enable_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mbus_slow_mode <= 1'b0;
    end else begin
      mbus_slow_mode <= sampled_r.mbus_slow;
    end
  end

  // configuration outputs
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      refclk_is_125 <= 1'b0;
    end else begin
      refclk_is_125 <= sampled_r.refclk_hi;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ssc_must_disable <= 1'b0;
    end else begin
      ssc_must_disable <= ssc_must_disable_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode_reserved <= 1'b0;
    end else begin
      mode_reserved <= mode_reserved_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cold_reset_seen <= 1'b0;
    end else begin
      cold_reset_seen <= powered_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      switch_status_register <= '0;
    end else begin
      switch_status_register <= status_nxt_w;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      boot_active <= '0;
    end else begin
      boot_active <= sampled_r;
    end
  end
endmodule : bcr_reset_ctrl
`default_nettype wire

// file: core/bcr_consts.svh
// bcr_consts.svh: frequencies, codes and timing counts for the boot config / reset block
// assumes inclusion by bare name from the package and the module
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH
`define BCR_REFCLK_LO_MHZ 100
`define BCR_REFCLK_HI_MHZ 125
`define BCR_LANE_CLK_MHZ 2500
`define BCR_CORE_CLK_MHZ 250
`define BCR_MBUS_FAST_KHZ 400
`define BCR_MBUS_SLOW_KHZ 100
`define BCR_MODE_NORMAL 4'h0
`define BCR_MODE_NORMAL_EEPROM 4'h1
`define BCR_MODE_W 4
`define BCR_SETTLE_CYC 8'h10
`endif

// file: core/bcr_pkg.sv
// bcr_pkg.sv: types for the boot config / reset block
// assumes bcr_consts.svh on the include path
`include "bcr_consts.svh"
package bcr_pkg;
  typedef struct packed {
    logic [`BCR_MODE_W-1:0] mode;
    logic halt;
    logic mbus_slow;
    logic cclk_us;
    logic cclk_ds;
    logic refclk_hi;
  } bcr_boot_s;
  typedef enum logic [2:0] {
    BCR_ST_RESET,
    BCR_ST_SAMPLE,
    BCR_ST_INIT,
    BCR_ST_HALT,
    BCR_ST_RUN
  } bcr_state_e;
endpackage : bcr_pkg

// file: test/bcr_chk_sva.sv
// bcr_chk_sva.sv: port checks for bcr_reset_ctrl
// assumes bcr_pkg compiled first; bound to the design below
`timescale 1ns/1ps
`default_nettype none
module bcr_chk import bcr_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic fundamental_reset_n,
  input wire logic halt_clear,
  input wire logic ds_sec_bus_reset_req,
  input wire logic core_reset_n,
  input wire logic ds_link_hot_reset,
  input wire logic mbus_slow_mode,
  input wire logic refclk_is_125,
  input wire logic ssc_must_disable,
  input wire logic mode_reserved,
  input wire bcr_boot_s switch_status_register,
  input wire bcr_boot_s boot_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_PIN: assert property ($fell(fundamental_reset_n) |-> ##[1:5] !core_reset_n) else $error("pin");
  AST_REF: assert property (core_reset_n |-> refclk_is_125 == boot_active.refclk_hi) else $error("ref");
  AST_SLOW: assert property (core_reset_n |-> mbus_slow_mode == boot_active.mbus_slow) else $error("slow");
  AST_SSC: assert property (core_reset_n |-> ssc_must_disable != (boot_active.cclk_us && boot_active.cclk_ds))
    else $error("ssc");
  AST_MODE: assert property (core_reset_n |-> mode_reserved == (boot_active.mode > 4'h1)) else $error("mode");
  AST_HOLD: assert property (core_reset_n ##1 core_reset_n |-> $stable(boot_active)) else $error("hold");
  AST_HALT: assert property (switch_status_register.halt && !core_reset_n && !halt_clear && !$past(halt_clear)
    |=> !core_reset_n) else $error("halt");
  AST_DS: assert property (ds_sec_bus_reset_req && core_reset_n |-> ##[1:2] ds_link_hot_reset) else $error("ds");
  cover property ($rose(core_reset_n));
  cover property (switch_status_register.halt && !core_reset_n);
  cover property (ds_link_hot_reset);
endmodule : bcr_chk
bind bcr_reset_ctrl bcr_chk bcr_chk_inst (.*);
`default_nettype wire

// file: test/bcr_board.sv
// bcr_board.sv: strap pins and system reset source
// assumes the bench picks strap values and reset timing
`timescale 1ns/1ps
`default_nettype none
module bcr_board import bcr_pkg::*; (
  input wire logic core_clk,
  input wire bcr_boot_s strap_set,
  input wire logic reset_hold,
  input wire logic strap_wild,
  output bcr_boot_s strap_pins,
  output logic fundamental_reset_n
);
  assign fundamental_reset_n = !reset_hold;
  always_ff @(posedge core_clk) if (reset_hold || strap_wild) strap_pins <= strap_set;
endmodule : bcr_board
`default_nettype wire

// file: test/test_boot_config_reset_control.sv
// test_boot_config_reset_control.sv: scenario bench for bcr_reset_ctrl
// assumes bcr_board drives straps and pin, bcr_chk bound to the design
`timescale 1ns/1ps
`default_nettype none
module test_boot_config_reset_control import bcr_pkg::*; ;
  logic core_clk = 1'b0, rstn = 1'b0, reset_hold = 1'b1, strap_wild = 1'b0, halt_clear = 1'b0, hot_reset_req = 1'b0;
  logic fundamental_reset_request = 1'b0, us_sec_bus_reset_req = 1'b0, ds_sec_bus_reset_req = 1'b0, ovr_valid = 1'b0;
  logic eeprom_init_done = 1'b0, fundamental_reset_n, refclk_freq_select, common_clock_upstream, halt_after_reset;
  logic common_clock_downstream, master_mgmt_bus_slow_select, eeprom_init_start, core_reset_n, sticky_reset_n;
  logic link_fund_reset, vbus_hot_reset, us_bridge_hot_reset, ds_link_hot_reset, mgmt_bus_enable, mbus_slow_mode;
  logic refclk_is_125, ssc_must_disable, mode_reserved, cold_reset_seen;
  logic [3:0] switch_operating_mode_sel;
  bcr_boot_s ovr_boot = '0, strap_set = 9'h00D, switch_status_register, boot_active, strap_pins;
  int n_fail = 0, comparisons = 0, n_init = 0;
  assign {switch_operating_mode_sel, halt_after_reset, master_mgmt_bus_slow_select, common_clock_upstream,
    common_clock_downstream, refclk_freq_select} = strap_pins;
  bcr_board bcr_board_inst (.*);
  bcr_reset_ctrl bcr_reset_ctrl_inst (.*);
  initial forever #20 core_clk = !core_clk;
  always @(posedge core_clk) eeprom_init_done <= eeprom_init_start;
  always @(posedge core_clk) if (eeprom_init_start === 1'b1) n_init++;
  task automatic chk(input logic ok, input string what);
    comparisons++;
    n_fail += (ok !== 1'b1);
    if (ok !== 1'b1) $display("Error at %0t: %s", $time, what);
  endtask : chk
  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic wait_core(input logic lvl);
    for (int i = 0; i < 300 && core_reset_n !== lvl; i++) @(negedge core_clk);
    chk(core_reset_n === lvl, "reset level");
    if (core_reset_n !== lvl) give_verdict();
  endtask : wait_core
  task automatic pin_boot(input bcr_boot_s s);
    int n0;
    n0 = n_init;
    @(posedge core_clk) strap_set <= s;
    reset_hold <= 1'b1;
    repeat (6) @(negedge core_clk);
    chk({link_fund_reset, core_reset_n} === 2'b10, "pin");
    @(posedge core_clk) reset_hold <= 1'b0;
    if (s.halt) begin
      repeat (60) @(negedge core_clk);
      chk({core_reset_n, mgmt_bus_enable, switch_status_register.halt} === 3'b011, "halt");
      @(posedge core_clk) halt_clear <= 1'b1;
      @(posedge core_clk) halt_clear <= 1'b0;
    end
    wait_core(1'b1);
    chk({boot_active, refclk_is_125, mbus_slow_mode} === {s, s.refclk_hi, s.mbus_slow}, "vector");
    chk({ssc_must_disable, mode_reserved} === {!(s.cclk_us && s.cclk_ds), s.mode > 4'h1}, "mode");
    chk((switch_status_register & 9'h1EF) === 9'h00D, "cold");
    chk(cold_reset_seen === 1'b1 && (n_init - n0) == (s.mode == 4'h1), "init");
  endtask : pin_boot
  task automatic ovr_boot_chk();
    @(posedge core_clk) strap_set <= 9'h00D;
    {reset_hold, ovr_valid} <= 2'b11;
    ovr_boot <= 9'h0A6;
    repeat (6) @(negedge core_clk);
    @(posedge core_clk) reset_hold <= 1'b0;
    wait_core(1'b1);
    chk({boot_active, mbus_slow_mode} === {9'h0AE, 1'b1}, "override");
    @(posedge core_clk) ovr_valid <= 1'b0;
  endtask : ovr_boot_chk
  task automatic warm_req();
    @(posedge core_clk) strap_set <= 9'h1F2;
    {strap_wild, fundamental_reset_request} <= 2'b11;
    @(posedge core_clk) fundamental_reset_request <= 1'b0;
    wait_core(1'b0);
    wait_core(1'b1);
    chk(boot_active === 9'h1E1, "warm");
  endtask : warm_req
  task automatic bus_resets();
    @(posedge core_clk) {ds_sec_bus_reset_req, us_sec_bus_reset_req} <= 2'b11;
    repeat (3) @(negedge core_clk);
    chk({ds_link_hot_reset, vbus_hot_reset, us_bridge_hot_reset} === 3'b110, "bus");
    @(posedge core_clk) {ds_sec_bus_reset_req, us_sec_bus_reset_req, hot_reset_req} <= 3'b001;
    repeat (3) @(negedge core_clk);
    chk({sticky_reset_n, us_bridge_hot_reset, core_reset_n} === 3'b110, "hot");
    @(posedge core_clk) hot_reset_req <= 1'b0;
    wait_core(1'b1);
  endtask : bus_resets
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    pin_boot(9'h00D);
    pin_boot(9'h02F);
    pin_boot(9'h056);
    ovr_boot_chk();
    pin_boot(9'h1E1);
    warm_req();
    bus_resets();
    give_verdict();
  end
endmodule : test_boot_config_reset_control
`default_nettype wire
